// >>> hw/flash_mode_pkg.sv
/*
 * Constants for the flash mode and boot select block: register offsets,
 * control bit positions, command codes, status bits and the area map.
 * Assumes a 16-bit CPU address space and 32-bit Wishbone data.
 */
package flash_mode_pkg;

   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_ADDR = 5'h04;
   localparam logic [4:0] OFS_CMD = 5'h08;
   localparam logic [4:0] OFS_DATA = 5'h0C;
   localparam logic [4:0] OFS_MODE = 5'h10;

   // ------------------------------------------------------------------
   // Control register bits
   // ------------------------------------------------------------------
   localparam int CTRL_READY = 0;
   localparam int CTRL_RW_SEL = 1;
   localparam int CTRL_RW_ENTRY = 2;
   localparam int CTRL_FL_RESET = 3;
   localparam int CTRL_AREA_SEL = 4;
   localparam int CTRL_PROT_EN = 5;

   // ------------------------------------------------------------------
   // Mode register bits (read only)
   // ------------------------------------------------------------------
   localparam int MODE_BOOT = 0;
   localparam int MODE_PARALLEL = 1;
   localparam int MODE_SERIAL = 2;
   localparam int MODE_REWRITE = 3;
   localparam int MODE_PROT_ACT = 4;
   localparam int MODE_FACTORY = 5;

   // ------------------------------------------------------------------
   // Command codes and status register bits
   // ------------------------------------------------------------------
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_PROGRAM = 8'h40;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
   localparam int SR_READY = 7;
   localparam int SR_ERASE_ERR = 5;
   localparam int SR_PROG_ERR = 4;

   // ------------------------------------------------------------------
   // Area map and start vector
   // ------------------------------------------------------------------
   localparam logic [15:0] BLK1_BASE = 16'h1000;
   localparam logic [15:0] BLK0_BASE = 16'h8000;
   localparam logic [15:0] BOOT_BASE = 16'hF000;
   localparam logic [15:0] VEC_LO = 16'hFFFC;
   localparam logic [15:0] VEC_HI = 16'hFFFD;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   typedef enum logic [1:0] {
      BLK_NONE,
      BLK_USER0,
      BLK_USER1,
      BLK_BOOT
   } block_e;

   typedef enum {
      ST_READ_ARRAY,
      ST_READ_STATUS,
      ST_WAIT_PROG,
      ST_WAIT_ERASE
   } cmd_state_e;

endpackage

// >>> hw/flash_mode_ctrl.sv
/*
 * Flash mode and boot select controller: Wishbone register slave,
 * start-up strap capture, area mapping, command sequencer and write
 * protection in front of the flash array macro.
 * Assumes the array macro runs on clk_i, reports busy for the length of
 * each operation and returns read data combinationally for arr_addr_o.
 */
// Notes on behaviour
// - Three access modes: parallel programmer, serial programmer, CPU rewrite.
// - User area is split into blocks, each erased as a whole.
// - Program and erase driven by exactly five software commands.
// - Boot area modified only in parallel programmer mode, else ignored.
// - CPU rewrite mode may program or erase the user area only.
// - No flash fetch or read during rewrite; routine runs from RAM.
// - User map: block 0 8000h-FFFFh, block 1 1000h-7FFFh.
// - Area select 1 maps 4K boot area at F000h-FFFFh.
// - Rewrite routine may be copied from user or boot area.
// - Replaced factory boot contents disable the serial programmer mode.
// - Boot select low at reset release gives normal user start-up.
// - Boot select and strap high give boot mode, vector FFFCh/FFFDh.
// - In boot mode a boot routine may rewrite the user area.
// - Read protection acts in programmer modes, never in rewrite mode.
// - Entering boot mode forces area select to 1.
`timescale 1ns/100ps
module flash_mode_ctrl (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Strap pins
   input wire logic boot_select_pin_i,
   input wire logic strap_port_pin_i,
   input wire logic par_mode_pin_i,
   // Flash array macro
   input wire logic arr_busy_i,
   input wire logic [7:0] arr_rdata_i,
   input wire logic factory_boot_ok_i,
   output logic [15:0] arr_addr_o,
   output logic [7:0] arr_wdata_o,
   output logic [1:0] arr_block_o,
   output logic arr_prog_o,
   output logic arr_erase_o,
   // Status to the core
   output logic boot_mode_o,
   output logic fetch_block_o,
   output logic vec_boot_area_o,
   output logic serial_mode_o
);

   // -------------------------------------------------------------
   // Area map
   // -------------------------------------------------------------
   // Boot area overlays the top of the user map when selected
   function automatic flash_mode_pkg::block_e map_block(
      input logic [15:0] a, input logic area_sel);
      if (area_sel && a >= flash_mode_pkg::BOOT_BASE)
         return flash_mode_pkg::BLK_BOOT;
      else if (a >= flash_mode_pkg::BLK0_BASE)
         return flash_mode_pkg::BLK_USER0;
      else if (a >= flash_mode_pkg::BLK1_BASE)
         return flash_mode_pkg::BLK_USER1;
      else
         return flash_mode_pkg::BLK_NONE;
   endfunction

   // -------------------------------------------------------------
   // Strap synchronisers and capture
   // -------------------------------------------------------------
   logic [1:0] boot_sync;
   logic [1:0] strap_sync;
   logic [1:0] par_sync;
   logic [1:0] settle_cnt;
   logic strap_done;
   logic boot_mode;
   logic par_mode;

   // Two flops per pin; only stage 1 is ever read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         boot_sync <= 2'h0;
         strap_sync <= 2'h0;
         par_sync <= 2'h0;
      end else begin
         boot_sync <= {boot_sync[0], boot_select_pin_i};
         strap_sync <= {strap_sync[0], strap_port_pin_i};
         par_sync <= {par_sync[0], par_mode_pin_i};
      end
   end

   // Capture once the chain has filled after release; later pin moves
   // are ignored until the next reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         settle_cnt <= 2'h0;
         strap_done <= 1'b0;
         boot_mode <= 1'b0;
         par_mode <= 1'b0;
      end else if (!strap_done) begin
         if (settle_cnt == flash_mode_pkg::STRAP_SETTLE) begin
            strap_done <= 1'b1;
            boot_mode <= boot_sync[1] & strap_sync[1];
            par_mode <= par_sync[1];
         end else begin
            settle_cnt <= settle_cnt + 2'h1;
         end
      end
   end

   // -------------------------------------------------------------
   // Register state and decode
   // -------------------------------------------------------------
   logic rw_sel;
   logic rw_armed;
   logic fl_reset;
   logic area_sel;
   logic prot_en;
   logic [15:0] addr_reg;
   logic sr_prog_err;
   logic sr_erase_err;
   logic launch;
   flash_mode_pkg::cmd_state_e cmd_state;
   logic bus_req;
   logic wr_ctrl;
   logic wr_addr;
   logic wr_cmd;
   logic wr_data;
   logic serial_mode;
   logic prot_act;
   logic busy;
   logic cmd_ok;
   flash_mode_pkg::block_e tgt_blk;
   logic tgt_writable;

   // One access per request; ack ends it, so no double decode
   assign bus_req = cyc_i & stb_i & ~ack_o;
   always_comb begin
      wr_ctrl = 1'b0;
      wr_addr = 1'b0;
      wr_cmd = 1'b0;
      wr_data = 1'b0;
      if (bus_req && we_i && sel_i[0]) begin
         if (adr_i == flash_mode_pkg::OFS_CTRL)
            wr_ctrl = 1'b1;
         else if (adr_i == flash_mode_pkg::OFS_ADDR)
            wr_addr = 1'b1;
         else if (adr_i == flash_mode_pkg::OFS_CMD)
            wr_cmd = 1'b1;
         else if (adr_i == flash_mode_pkg::OFS_DATA)
            wr_data = 1'b1;
      end
   end

   // Serial programmer needs the factory boot routine in place
   assign serial_mode = boot_mode & factory_boot_ok_i;
   assign prot_act = prot_en & (par_mode | serial_mode) & ~rw_sel;
   assign busy = arr_busy_i | launch;
   // Commands only in parallel mode or once rewrite is selected
   assign cmd_ok = (par_mode | rw_sel) & ~fl_reset & ~busy;
   assign tgt_blk = map_block(addr_reg, area_sel);
   // Boot area is writable from the parallel programmer alone
   always_comb begin
      if (tgt_blk == flash_mode_pkg::BLK_NONE)
         tgt_writable = 1'b0;
      else if (tgt_blk == flash_mode_pkg::BLK_BOOT)
         tgt_writable = par_mode;
      else
         tgt_writable = 1'b1;
   end

   // Control bits; rewrite select needs a 0 then a 1 written in turn
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rw_sel <= 1'b0;
         rw_armed <= 1'b0;
         fl_reset <= 1'b0;
         area_sel <= 1'b0;
         prot_en <= 1'b0;
      end else if (strap_done == 1'b0) begin
         area_sel <= boot_sync[1] & strap_sync[1];
      end else if (wr_ctrl) begin
         rw_armed <= ~dat_i[flash_mode_pkg::CTRL_RW_SEL];
         if (!dat_i[flash_mode_pkg::CTRL_RW_SEL])
            rw_sel <= 1'b0;
         else if (rw_armed)
            rw_sel <= 1'b1;
         fl_reset <= dat_i[flash_mode_pkg::CTRL_FL_RESET] &
            (rw_sel | par_mode);
         area_sel <= dat_i[flash_mode_pkg::CTRL_AREA_SEL];
         prot_en <= dat_i[flash_mode_pkg::CTRL_PROT_EN];
      end
   end

   // Target address register
   always_ff @(posedge clk_i) begin
      if (rst_i)
         addr_reg <= 16'h0000;
      else if (wr_addr && sel_i[1])
         addr_reg <= dat_i[15:0];
      else if (wr_addr)
         addr_reg <= {addr_reg[15:8], dat_i[7:0]};
   end

   // -------------------------------------------------------------
   // Command sequencer
   // -------------------------------------------------------------
   // Second cycle of program/erase launches one array operation
   always_ff @(posedge clk_i) begin
      if (rst_i || fl_reset) begin
         cmd_state <= flash_mode_pkg::ST_READ_ARRAY;
         launch <= 1'b0;
         arr_prog_o <= 1'b0;
         arr_erase_o <= 1'b0;
         arr_wdata_o <= 8'h00;
         arr_block_o <= 2'h0;
      end else begin
         launch <= 1'b0;
         arr_prog_o <= 1'b0;
         arr_erase_o <= 1'b0;
         if (wr_cmd && cmd_ok) begin
            case (dat_i[7:0])
               flash_mode_pkg::CMD_READ_ARRAY:
                  cmd_state <= flash_mode_pkg::ST_READ_ARRAY;
               flash_mode_pkg::CMD_READ_STATUS:
                  cmd_state <= flash_mode_pkg::ST_READ_STATUS;
               flash_mode_pkg::CMD_PROGRAM:
                  cmd_state <= flash_mode_pkg::ST_WAIT_PROG;
               flash_mode_pkg::CMD_ERASE:
                  cmd_state <= flash_mode_pkg::ST_WAIT_ERASE;
               default: ;
            endcase
         end else if (wr_data && cmd_ok) begin
            case (cmd_state)
               flash_mode_pkg::ST_WAIT_PROG: begin
                  cmd_state <= flash_mode_pkg::ST_READ_STATUS;
                  if (tgt_writable) begin
                     launch <= 1'b1;
                     arr_prog_o <= 1'b1; // one byte
                     arr_wdata_o <= dat_i[7:0];
                     arr_block_o <= tgt_blk;
                  end
               end
               flash_mode_pkg::ST_WAIT_ERASE: begin
                  cmd_state <= flash_mode_pkg::ST_READ_STATUS;
                  if (tgt_writable &&
                      dat_i[7:0] == flash_mode_pkg::CMD_ERASE_CONFIRM) begin
                     launch <= 1'b1;
                     arr_erase_o <= 1'b1; // whole block
                     arr_block_o <= tgt_blk;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // Error flags: a new error in the clearing cycle wins over the clear
   always_ff @(posedge clk_i) begin
      if (rst_i || fl_reset) begin
         sr_prog_err <= 1'b0;
         sr_erase_err <= 1'b0;
      end else if (wr_data && cmd_ok &&
                   cmd_state == flash_mode_pkg::ST_WAIT_PROG &&
                   !tgt_writable) begin
         sr_prog_err <= 1'b1; // refused, array untouched
      end else if (wr_data && cmd_ok &&
                   cmd_state == flash_mode_pkg::ST_WAIT_ERASE &&
                   (!tgt_writable ||
                    dat_i[7:0] != flash_mode_pkg::CMD_ERASE_CONFIRM)) begin
         sr_erase_err <= 1'b1;
         sr_prog_err <= sr_prog_err |
            (dat_i[7:0] != flash_mode_pkg::CMD_ERASE_CONFIRM);
      end else if (wr_cmd && cmd_ok &&
                   dat_i[7:0] == flash_mode_pkg::CMD_CLEAR_STATUS) begin
         sr_prog_err <= 1'b0;
         sr_erase_err <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Bus answer and outputs
   // -------------------------------------------------------------
   // Every access, mapped or not, answers one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i)
         ack_o <= 1'b0;
      else
         ack_o <= bus_req;
   end

   // Read mux; array data hidden while busy or read-protected
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (bus_req && !we_i) begin
         dat_o <= 32'h0000_0000;
         if (adr_i == flash_mode_pkg::OFS_CTRL) begin
            dat_o[flash_mode_pkg::CTRL_READY] <= ~busy;
            dat_o[flash_mode_pkg::CTRL_RW_SEL] <= rw_sel;
            dat_o[flash_mode_pkg::CTRL_RW_ENTRY] <= rw_sel;
            dat_o[flash_mode_pkg::CTRL_FL_RESET] <= fl_reset;
            dat_o[flash_mode_pkg::CTRL_AREA_SEL] <= area_sel;
            dat_o[flash_mode_pkg::CTRL_PROT_EN] <= prot_en;
         end else if (adr_i == flash_mode_pkg::OFS_ADDR) begin
            dat_o[15:0] <= addr_reg;
         end else if (adr_i == flash_mode_pkg::OFS_DATA) begin
            if (cmd_state == flash_mode_pkg::ST_READ_STATUS) begin
               dat_o[flash_mode_pkg::SR_READY] <= ~busy;
               dat_o[flash_mode_pkg::SR_ERASE_ERR] <= sr_erase_err;
               dat_o[flash_mode_pkg::SR_PROG_ERR] <= sr_prog_err;
            end else if (cmd_state == flash_mode_pkg::ST_READ_ARRAY &&
                         !prot_act && !busy &&
                         tgt_blk != flash_mode_pkg::BLK_NONE) begin
               dat_o[7:0] <= arr_rdata_i;
            end
         end else if (adr_i == flash_mode_pkg::OFS_MODE) begin
            dat_o[flash_mode_pkg::MODE_BOOT] <= boot_mode;
            dat_o[flash_mode_pkg::MODE_PARALLEL] <= par_mode;
            dat_o[flash_mode_pkg::MODE_SERIAL] <= serial_mode;
            dat_o[flash_mode_pkg::MODE_REWRITE] <= rw_sel;
            dat_o[flash_mode_pkg::MODE_PROT_ACT] <= prot_act;
            dat_o[flash_mode_pkg::MODE_FACTORY] <= factory_boot_ok_i;
         end
      end
   end

   // Array address follows the address register; held during busy
   always_ff @(posedge clk_i) begin
      if (rst_i)
         arr_addr_o <= 16'h0000;
      else if (!busy)
         arr_addr_o <= addr_reg;
   end

   // Core-facing status flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         boot_mode_o <= 1'b0;
         fetch_block_o <= 1'b0;
         vec_boot_area_o <= 1'b0;
         serial_mode_o <= 1'b0;
      end else begin
         boot_mode_o <= boot_mode;
         fetch_block_o <= rw_sel; // core must run from RAM
         vec_boot_area_o <= boot_mode; // vector from boot area
         serial_mode_o <= serial_mode & strap_done;
      end
   end

endmodule

// >>> dv/flash_mode_ctrl_checker.sv
/* Port checker for flash_mode_ctrl: bus handshake, launch pulses,
   area map and start-up mode. Bound to every instance of the block;
   assumes the strap pins stay put while a phase runs. */
`timescale 1ns/100ps
module flash_mode_ctrl_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus and pins
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic par_mode_pin_i,
   input wire logic boot_select_pin_i,
   input wire logic strap_port_pin_i,
   input wire logic factory_boot_ok_i,
   // Array side and status
   input wire logic [15:0] arr_addr_o,
   input wire logic [1:0] arr_block_o,
   input wire logic arr_prog_o,
   input wire logic arr_erase_o,
   input wire logic boot_mode_o,
   input wire logic vec_boot_area_o,
   input wire logic serial_mode_o
);
   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [2:0] age;
   logic exp_boot;
   // Edges since reset; mode outputs settle before it saturates
   always_ff @(posedge clk_i) begin
      if (rst_i) age <= 3'h0;
      else if (age != 3'h7) age <= age + 3'h1;
   end
   // Expected start-up mode, taken while the straps still stand
   always_ff @(posedge clk_i) begin
      if (age == 3'h1) exp_boot <= boot_select_pin_i & strap_port_pin_i;
   end
   sequence req_s;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence launch_s;
      arr_prog_o || arr_erase_o;
   endsequence
   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   ack_answer_a: assert property (req_s |=> ack_o)
      else $error("bus request not answered next cycle");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   launch_pulse_a: assert property (
      launch_s |=> !arr_prog_o && !arr_erase_o)
      else $error("launch pulse longer than one cycle");
   boot_guard_a: assert property (
      (arr_prog_o || arr_erase_o) && arr_block_o == 2'h3
      |-> par_mode_pin_i)
      else $error("boot area modified outside parallel mode");
   block_map_a: assert property (
      launch_s ##0 arr_block_o != 2'h3 |-> arr_block_o ==
      (arr_addr_o >= 16'h8000 ? 2'h1 : 2'h2))
      else $error("user block does not match address");
   vec_boot_a: assert property (
      age == 3'h7 |-> vec_boot_area_o == exp_boot &&
      boot_mode_o == exp_boot)
      else $error("start-up mode differs from strap pins");
   serial_mode_a: assert property (
      age == 3'h7 |-> serial_mode_o ==
      (boot_mode_o && factory_boot_ok_i))
      else $error("serial mode without factory boot code");
   strap_hold_a: assert property (
      age == 3'h7 |=> $stable(boot_mode_o))
      else $error("start-up mode changed after capture");
endmodule
bind flash_mode_ctrl flash_mode_ctrl_checker chk_u (.clk_i, .rst_i,
   .cyc_i, .stb_i, .ack_o, .par_mode_pin_i, .factory_boot_ok_i,
   .boot_select_pin_i, .strap_port_pin_i,
   .arr_addr_o, .arr_block_o, .arr_prog_o, .arr_erase_o,
   .boot_mode_o, .vec_boot_area_o, .serial_mode_o);

// >>> dv/flash_array_model.sv
/* Behavioural flash array facing flash_mode_ctrl.
   Assumes one clock; busy length set by BUSY_CYC. */
`timescale 1ns/100ps
module flash_array_model #(
   parameter int BUSY_CYC = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Requests
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [1:0] block_i,
   input wire logic prog_i,
   input wire logic erase_i,
   // Answers
   output logic busy_o,
   output logic [7:0] rdata_o,
   output logic factory_ok_o
);
   logic [7:0] mem [0:65535];
   logic [7:0] boot [0:4095];
   int cnt;
   logic dirty;
   // Blank array at start, factory boot routine intact
   initial begin
      dirty = 1'b0;
      for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
      for (int i = 0; i < 4096; i++) boot[i] = 8'hFF;
   end
   // Busy count, byte program and whole-block erase
   always @(posedge clk_i) begin
      if (rst_i) cnt <= 0;
      else if (prog_i || erase_i) cnt <= BUSY_CYC;
      else if (cnt > 0) cnt <= cnt - 1;
      if (prog_i && block_i == 2'h3)
         boot[addr_i[11:0]] <= boot[addr_i[11:0]] & wdata_i;
      else if (prog_i) mem[addr_i] <= mem[addr_i] & wdata_i;
      // Any boot area change replaces the factory routine for good
      if ((prog_i || erase_i) && block_i == 2'h3) dirty <= 1'b1;
      if (erase_i) begin
         for (int i = 4096; i < 65536; i++)
            if ((i >= 32768 ? 2'h1 : 2'h2) == block_i) mem[i] <= 8'hFF;
      end
   end
   // Data is junk that changes each cycle while busy
   assign busy_o = cnt != 0;
   assign rdata_o = busy_o ? 8'hA5 ^ 8'(cnt) : mem[addr_i];
   assign factory_ok_o = ~dirty;
endmodule

// >>> dv/tb_flash_mode_ctrl.sv
/* Self-checking bench for flash_mode_ctrl with a flash array model.
   Assumes the package constants and the hand-over bus timing. */
`timescale 1ns/100ps
module tb_flash_mode_ctrl;
   logic clk_i, rst_i, cyc_i, stb_i, we_i;
   logic [4:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, q;
   logic ack_o, boot_select_pin_i, strap_port_pin_i, par_mode_pin_i;
   logic busy, fok, prog, erase;
   logic [7:0] rdata, wdata, d;
   logic [15:0] addr, a;
   logic [1:0] blk, last_blk;
   logic boot_mode_o, fetch_block_o, vec_boot_area_o, serial_mode_o;
   int errors, cmp_count, npulse, n0;

   flash_mode_ctrl dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
      .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .boot_select_pin_i,
      .strap_port_pin_i, .par_mode_pin_i, .arr_busy_i(busy),
      .arr_rdata_i(rdata), .factory_boot_ok_i(fok), .arr_addr_o(addr),
      .arr_wdata_o(wdata), .arr_block_o(blk), .arr_prog_o(prog),
      .arr_erase_o(erase), .boot_mode_o, .fetch_block_o,
      .vec_boot_area_o, .serial_mode_o);
   flash_array_model #(.BUSY_CYC(4)) arr_u (.clk_i, .rst_i,
      .addr_i(addr), .wdata_i(wdata), .block_i(blk), .prog_i(prog),
      .erase_i(erase), .busy_o(busy), .rdata_o(rdata),
      .factory_ok_o(fok));

   // Clock at 100 MHz
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Count launch pulses and note their block
   always @(posedge clk_i) begin
      if (prog || erase) begin
         npulse++;
         last_blk = blk;
      end
   end
   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One classic cycle; the wait is bounded, not assumed
   task automatic wb(input logic w, input logic [4:0] ad,
                     input logic [31:0] wd);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= 4'hF;
      adr_i <= ad;
      dat_i <= wd;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 40);
      chk({31'h0, ack_o}, 32'h1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic op(input logic [15:0] ad, input logic [7:0] c,
                     input logic [7:0] v);
      int n;
      wb(1'b1, flash_mode_pkg::OFS_ADDR, {16'h0, ad});
      wb(1'b1, flash_mode_pkg::OFS_CMD, {24'h0, c});
      wb(1'b1, flash_mode_pkg::OFS_DATA, {24'h0, v});
      n = 0;
      do begin
         wb(1'b0, flash_mode_pkg::OFS_CTRL, 32'h0);
         n++;
      end while (q[flash_mode_pkg::CTRL_READY] !== 1'b1 && n < 40);
   endtask
   task automatic start(input logic b, input logic s, input logic p);
      @(posedge clk_i);
      rst_i <= 1'b1;
      boot_select_pin_i <= b;
      strap_port_pin_i <= s;
      par_mode_pin_i <= p;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask
   function automatic logic [1:0] exp_blk(input logic [15:0] ad);
      return (ad >= flash_mode_pkg::BLK0_BASE) ? 2'h1 : 2'h2;
   endfunction
   task automatic stop_test;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      #200000;
      errors++;
      stop_test();
   end
   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
      rst_i = 1'b1;
      {boot_select_pin_i, strap_port_pin_i, par_mode_pin_i} = '0;
      sel_i = 4'hF;
      {errors, cmp_count, npulse} = '0;
      void'($urandom(32'hc14e));
      start(1'b0, 1'b0, 1'b1);
      chk(boot_mode_o, 1'b0);
      wb(1'b0, flash_mode_pkg::OFS_MODE, 32'h0);
      chk(q[3:0], 4'h2);
      wb(1'b0, 5'h14, 32'h0);
      chk(q, 32'h0);
      d = 8'($urandom);
      op(16'h1234, flash_mode_pkg::CMD_PROGRAM, d);
      wb(1'b1, flash_mode_pkg::OFS_CMD, 32'hFF);
      wb(1'b0, flash_mode_pkg::OFS_DATA, 32'h0);
      chk(q[7:0], d);
      op(16'h1000, 8'h20, flash_mode_pkg::CMD_ERASE_CONFIRM);
      wb(1'b1, flash_mode_pkg::OFS_ADDR, 32'h1234);
      wb(1'b1, flash_mode_pkg::OFS_CMD, 32'hFF);
      wb(1'b0, flash_mode_pkg::OFS_DATA, 32'h0);
      chk(q[7:0], 8'hFF);
      // Protection hides the array from a programmer
      wb(1'b1, flash_mode_pkg::OFS_CTRL, 32'h20);
      wb(1'b0, flash_mode_pkg::OFS_DATA, 32'h0);
      chk(q[7:0], 8'h00);
      // Block edges first, then random user addresses
      for (int i = 0; i < 8; i++) begin
         a = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h8000 :
             16'h1000 + 16'($urandom_range(16'hEFFF));
         n0 = npulse;
         op(a, flash_mode_pkg::CMD_PROGRAM, 8'($urandom));
         chk(npulse, n0 + 1);
         chk(last_blk, exp_blk(a));
      end
      // Boot start-up while the factory routine is still in place
      start(1'b1, 1'b1, 1'b0);
      wb(1'b0, flash_mode_pkg::OFS_MODE, 32'h0);
      chk(q[5:0], 6'h25);
      wb(1'b1, flash_mode_pkg::OFS_CTRL, 32'h20);
      wb(1'b0, flash_mode_pkg::OFS_MODE, 32'h0);
      chk(q[4], 1'b1);
      wb(1'b1, flash_mode_pkg::OFS_CTRL, 32'h22);
      wb(1'b0, flash_mode_pkg::OFS_MODE, 32'h0);
      chk(q[4:3], 2'h1);
      start(1'b0, 1'b0, 1'b1);
      wb(1'b1, flash_mode_pkg::OFS_CTRL, 32'h10);
      n0 = npulse;
      op(16'hF800, flash_mode_pkg::CMD_PROGRAM, 8'h5A);
      chk(last_blk, 2'h3);
      chk(npulse, n0 + 1);
      // Boot start-up; pins move later without effect
      start(1'b1, 1'b1, 1'b0);
      chk(vec_boot_area_o, 1'b1);
      wb(1'b0, flash_mode_pkg::OFS_MODE, 32'h0);
      chk(q[5:0], 6'h01);
      wb(1'b0, flash_mode_pkg::OFS_CTRL, 32'h0);
      chk(q[4], 1'b1);
      boot_select_pin_i <= 1'b0;
      strap_port_pin_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(boot_mode_o, 1'b1);
      n0 = npulse;
      op(16'h8100, flash_mode_pkg::CMD_PROGRAM, 8'h00);
      chk(npulse, n0);
      wb(1'b1, flash_mode_pkg::OFS_CTRL, 32'h10);
      wb(1'b1, flash_mode_pkg::OFS_CTRL, 32'h12);
      wb(1'b0, flash_mode_pkg::OFS_CTRL, 32'h0);
      chk(q[2:1], 2'h3);
      chk(fetch_block_o, 1'b1);
      op(16'hF100, flash_mode_pkg::CMD_PROGRAM, 8'h00);
      chk(npulse, n0);
      wb(1'b0, flash_mode_pkg::OFS_DATA, 32'h0);
      chk(q[7:0], 8'h90);
      wb(1'b1, flash_mode_pkg::OFS_CMD, 32'h50);
      wb(1'b1, flash_mode_pkg::OFS_CMD, 32'h70);
      wb(1'b0, flash_mode_pkg::OFS_DATA, 32'h0);
      chk(q[7:0], 8'h80);
      wb(1'b1, flash_mode_pkg::OFS_CTRL, 32'h02);
      op(16'h8100, flash_mode_pkg::CMD_PROGRAM, 8'h3C);
      chk(last_blk, 2'h1);
      chk(npulse, n0 + 1);
      op(16'h8100, flash_mode_pkg::CMD_ERASE, 8'h11);
      wb(1'b0, flash_mode_pkg::OFS_DATA, 32'h0);
      chk(q[7:0], 8'hB0);
      chk(npulse, n0 + 1);
      stop_test();
   end
endmodule
